// *** test_ubg_top.sv ***
/* Testbench of ubg_top: Wishbone tasks and one task per drive scenario.
   Assumes ubg_pkg, ubg_top, its checker and the switch model. */
`timescale 1ns/1ps
module test_ubg_top;
   import ubg_pkg::*;
   localparam int HI = 2;
   localparam int LO = 6;
   localparam int GD = 1;
   logic        clk_i, rst_i, cyc_i, stb_i, we_i, pin, clr, ack_o, one, two, ovl;
   logic [7:0]  adr_i, ca, cb;
   logic [3:0]  sel_i;
   logic [31:0] dat_i, dat_o, rd;
   logic [15:0] ha, la, hb;
   int          n_fail, comparisons, cycles;

   ubg_top ubg_top_i (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
      .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .ack_o(ack_o), .dat_o(dat_o),
      .port_pin_for_b_i(pin), .low_switch_one_o(one), .low_switch_two_o(two));
   ubg_xducer_model ubg_xducer_model_i (.clk_i(clk_i), .clr_i(clr), .gate_a_i(one), .gate_b_i(two),
      .cnt_a_o(ca), .cnt_b_o(cb), .hi_a_o(ha), .lo_a_o(la), .hi_b_o(hb), .overlap_o(ovl));

   // Clock and hang guard
   initial
   begin
      clk_i = 1'b0;
      forever #2 clk_i = ~clk_i;
   end
   always @(posedge clk_i)
   begin
      cycles++;
      if (cycles == 30000)
      begin
         n_fail++;
         finish_test();
      end
   end

   task automatic finish_test;
      $display("mismatches %0d comparisons %0d", n_fail, comparisons);
      if (n_fail == 0 && comparisons > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : finish_test

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      comparisons++;
      if (got !== exp)
      begin
         n_fail++;
         $display("MISMATCH %0t %s got %0h exp %0h", $time, what, got, exp);
      end
   endtask : chk

   task automatic rng(input logic [15:0] got, input int n, input string what);
      chk(32'((got >= n * 15 - 1 && got <= n * 16 + 1) === 1'b1), 32'h1, what);
   endtask : rng

   // Classic single Wishbone cycle, held until ack
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i  <= w;
      adr_i <= a;
      dat_i <= d;
      sel_i <= 4'hF;
      n = 0;
      do
      begin
         @(posedge clk_i);
         n++;
      end
      while (ack_o !== 1'b1 && n < 20);
      rd = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      chk(32'(n < 20), 32'h1, "no ack");
   endtask : wb

   // Arm, trigger, then poll status until idle
   task automatic burst(input logic [31:0] ctrl, input logic [31:0] count);
      int n;
      wb(1'b1, OFS_COUNT, count);
      wb(1'b1, OFS_CTRL, ctrl);
      clr <= 1'b1;
      @(posedge clk_i);
      clr <= 1'b0;
      wb(1'b1, OFS_CTRL, ctrl | 32'h2);
      repeat (40) @(posedge clk_i);
      n = 0;
      do
      begin
         wb(1'b0, OFS_STATUS, 32'h0);
         n++;
      end
      while (rd[1:0] !== 2'b00 && n < 400);
      chk(rd[3:0], 32'h0, "not idle");
   endtask : burst

   task automatic t_reset;
      chk(32'({one, two}), 32'h0, "gates after reset");
      wb(1'b0, OFS_CTRL, 32'h0);
      chk(rd, 32'h0, "ctrl reset");
      wb(1'b0, 8'h20, 32'h0);
      chk(rd, 32'h0, "unmapped read");
   endtask : t_reset

   task automatic t_push_pull;
      wb(1'b1, OFS_GUARD, 32'(GD));
      wb(1'b1, OFS_TIME, (32'(LO) << TIME_LOW_LSB) | 32'(HI));
      burst(32'h1, (32'h2 << COUNT_B_LSB) | 32'h3);
      chk(32'(ca), 32'h3, "pulses A");
      chk(32'(cb), 32'h2, "pulses B");
      rng(ha, HI, "high A");
      rng(la, LO, "low A");
      rng(hb, LO - 2 * GD, "high B");
      chk(32'(ovl), 32'h0, "overlap");
      wb(1'b0, OFS_CTRL, 32'h0);
      chk(rd, 32'h1, "ctrl readback");
      burst(32'h1, 32'h0);
      chk(32'({ca, cb}), 32'h0, "zero count");
      burst(32'h0, 32'h3);
      chk(32'(ca), 32'h0, "inactive trigger");
   endtask : t_push_pull

   task automatic t_port;
      burst(32'h5, (32'h3 << COUNT_B_LSB) | 32'h2);
      chk(32'(ca), 32'h2, "port mode A");
      chk(32'(cb), 32'h0, "port mode B idle");
      pin <= 1'b1;
      repeat (2) @(posedge clk_i);
      chk(32'(two), 32'h1, "pin high");
      pin <= 1'b0;
      repeat (2) @(posedge clk_i);
      chk(32'({cb, two}), 32'h2, "pin low");
   endtask : t_port

   task automatic t_bad_modes;
      pin <= 1'b1;
      for (int m = 2; m < 8; m++)
      begin
         burst(32'h1 | (32'(m) << CTRL_MODE_LSB), 32'h0303);
         chk(32'({ca, cb, two}), 32'h0, "unsupported mode");
      end
      pin <= 1'b0;
   endtask : t_bad_modes

   // Main sequence
   initial
   begin
      {rst_i, clr} = 2'b11;
      {cyc_i, stb_i, we_i, pin} = 4'h0;
      {adr_i, sel_i, dat_i} = 44'h0;
      {n_fail, comparisons, cycles} = 96'h0;
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      clr   <= 1'b0;
      @(posedge clk_i);
      t_reset();
      t_push_pull();
      t_port();
      t_bad_modes();
      finish_test();
   end
endmodule : test_ubg_top

// *** ubg_chan.sv ***
/*
 * One burst channel: after a start pulse, waits a lead time, then emits
 * count pulses of high/low ticks. A zero high time keeps the slot but
 * leaves the output low.
 * Assumes tick_i is a one-cycle strobe at the 16 MHz rate.
 */
`timescale 1ns/1ps
module ubg_chan
(
   input  wire logic                  clk_i,
   input  wire logic                  rst_i,
   input  wire logic                  tick_i,
   input  wire logic                  start_i,
   input  wire ubg_pkg::ubg_chan_cfg_s cfg_i,
   output logic                       pulse_o,
   output logic                       busy_o
);
   import ubg_pkg::*;

   ubg_ch_state_e state;
   ubg_chan_cfg_s cfg;
   logic [11:0]   timer;
   logic [5:0]    left;

   // ***************************************************************
   // Sequencer
   // ***************************************************************
   // Phase timing and pulse counting
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         state <= UBG_CH_IDLE;
         timer <= 12'h000;
         left  <= 6'h00;
         cfg   <= '0;
      end
      else
      begin
         unique case (state)
            UBG_CH_IDLE:
            begin
               if (start_i && cfg_i.count != 6'h00)
               begin
                  cfg   <= cfg_i;
                  left  <= cfg_i.count;
                  timer <= cfg_i.lead;
                  state <= UBG_CH_LEAD;
               end
            end
            UBG_CH_LEAD:
            begin
               if (tick_i)
               begin
                  if (timer <= 12'h001)
                  begin
                     timer <= cfg.high;
                     state <= UBG_CH_HIGH;
                  end
                  else
                  begin
                     timer <= timer - 12'h001;
                  end
               end
            end
            UBG_CH_HIGH:
            begin
               if (tick_i)
               begin
                  if (timer <= 12'h001)
                  begin
                     timer <= cfg.low;
                     left  <= left - 6'h01;
                     state <= UBG_CH_LOW;
                  end
                  else
                  begin
                     timer <= timer - 12'h001;
                  end
               end
            end
            UBG_CH_LOW:
            begin
               if (tick_i && timer <= 12'h001)
               begin
                  timer <= cfg.high;
                  state <= (left == 6'h00) ? UBG_CH_IDLE : UBG_CH_HIGH;
               end
               else if (tick_i)
               begin
                  timer <= timer - 12'h001;
               end
            end
         endcase
      end
   end

   // Output high only in a non-empty high phase
   assign pulse_o = (state == UBG_CH_HIGH) && (cfg.high != 12'h000);
   assign busy_o  = (state != UBG_CH_IDLE);

endmodule : ubg_chan

// *** ubg_pkg.sv ***
/*
 * Package of the ultrasonic burst generator: register offsets, field
 * positions, reset values, drive configurations and tick timing.
 * Assumes a 250 MHz system clock and a 16 MHz burst time base.
 */
package ubg_pkg;

   // ***************************************************************
   // Clock and burst time base
   // ***************************************************************
   localparam int unsigned CLK_MHZ  = 250;
   localparam int unsigned TICK_MHZ = 16;
   localparam logic [7:0]  TICK_ADD = 8'(TICK_MHZ);
   localparam logic [7:0]  TICK_MOD = 8'(CLK_MHZ);

   // ***************************************************************
   // Register byte offsets
   // ***************************************************************
   localparam logic [7:0] OFS_CTRL   = 8'h00;
   localparam logic [7:0] OFS_COUNT  = 8'h04;
   localparam logic [7:0] OFS_TIME   = 8'h08;
   localparam logic [7:0] OFS_GUARD  = 8'h0C;
   localparam logic [7:0] OFS_STATUS = 8'h10;

   // ***************************************************************
   // Field positions
   // ***************************************************************
   localparam int CTRL_ACTIVE_BIT = 0;
   localparam int CTRL_TRIG_A_BIT = 1;
   localparam int CTRL_MODE_LSB   = 2;
   localparam int COUNT_B_LSB     = 8;
   localparam int TIME_LOW_LSB    = 16;

   // ***************************************************************
   // Reset values
   // ***************************************************************
   localparam logic [5:0]  RST_COUNT = 6'h00;
   localparam logic [10:0] RST_TIME  = 11'h000;
   localparam logic [7:0]  RST_GUARD = 8'h00;

   // ***************************************************************
   // Drive configurations
   // ***************************************************************
   typedef enum logic [2:0]
   {
      UBG_MODE_PUSH_PULL = 3'b000,
      UBG_MODE_PORT_B    = 3'b001
   } ubg_mode_e;

   // Channel states
   typedef enum logic [1:0]
   {
      UBG_CH_IDLE = 2'b00,
      UBG_CH_LEAD = 2'b01,
      UBG_CH_HIGH = 2'b10,
      UBG_CH_LOW  = 2'b11
   } ubg_ch_state_e;

   // Per-channel pulse train settings, in 16 MHz ticks
   typedef struct packed
   {
      logic [5:0]  count;
      logic [11:0] lead;
      logic [11:0] high;
      logic [11:0] low;
   } ubg_chan_cfg_s;

endpackage : ubg_pkg

// *** ubg_top.sv ***
/*
 * Ultrasonic burst generator: gate pulse trains for two low-side
 * switches, configured over a classic Wishbone slave.
 * Holds the control and timing registers, a fractional 16 MHz tick, two
 * burst channels and the registered gate selection.
 * Assumes a 250 MHz clock, synchronous active-high reset and a port
 * pin input already synchronous to the clock.
 */
// The Wishbone interface to the registers and the register addresses are this design's own decisions.
// Summary of operation
// - Three-bit field selects drive configuration
// - Generate gate pulse trains for low switches
// - Code 000 runs outputs as push-pull
// - Trigger bit write starts A, and B in 000
// - Output A emits programmed count, 0 to 63
// - Output B emits its own count, 0 to 63
// - High phase timed by 11-bit 16 MHz value
// - Low phase timed by 11-bit 16 MHz value
// - Eight-bit guard interval shapes push-pull timing
// - Push-pull B uses channel A timing values
// - Code 001: A from generator, B from pin
// - Single-ended mode: one switch drives primary (not implemented; codes other than 000 and 001 keep both gates off)
// - Push-pull mode: two switches alternate
// - Port mode: gate follows port pin level
`timescale 1ns/1ps
module ubg_top
(
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        cyc_i,
   input  wire logic        stb_i,
   input  wire logic        we_i,
   input  wire logic [7:0]  adr_i,
   input  wire logic [3:0]  sel_i,
   input  wire logic [31:0] dat_i,
   output logic             ack_o,
   output logic [31:0]      dat_o,
   input  wire logic        port_pin_for_b_i,
   output logic             low_switch_one_o,
   output logic             low_switch_two_o
);
   import ubg_pkg::*;

   // Register fields
   logic          active_en;
   logic [2:0]    mode;
   logic [5:0]    count_a;
   logic [5:0]    count_b;
   logic [10:0]   chan_a_high_time;
   logic [10:0]   chan_a_low_time;
   logic [7:0]    guard_interval;

   // Time base
   logic [7:0]    tick_acc;
   logic [8:0]    tick_sum;
   logic          tick;

   // Bus strobes and read-back
   logic          wr;
   logic          wr_ctrl;
   logic          wr_count;
   logic          wr_time;
   logic          wr_guard;
   logic          trig_a;
   logic [31:0]   rdata;

   // Channels and their settings
   logic          push_pull;
   logic          start_b;
   logic          pulse_a;
   logic          pulse_b;
   logic          busy_a;
   logic          busy_b;
   logic [11:0]   guard2;
   logic [11:0]   b_high;
   ubg_chan_cfg_s cfg_a;
   ubg_chan_cfg_s cfg_b;

   // ***************************************************************
   // Bus slave
   // ***************************************************************
   ubg_wb_slave u_slave
   (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .cyc_i   (cyc_i),
      .stb_i   (stb_i),
      .we_i    (we_i),
      .rdata_i (rdata),
      .ack_o   (ack_o),
      .dat_o   (dat_o),
      .wr_o    (wr)
   );

   // ***************************************************************
   // Registers
   // ***************************************************************
   // Write strobes per register, valid at the acking edge
   assign wr_ctrl  = wr && (adr_i == OFS_CTRL);
   assign wr_count = wr && (adr_i == OFS_COUNT);
   assign wr_time  = wr && (adr_i == OFS_TIME);
   assign wr_guard = wr && (adr_i == OFS_GUARD);

   // Control register: active enable and configuration
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         active_en <= 1'b0;
         mode      <= UBG_MODE_PUSH_PULL;
      end
      else if (wr_ctrl && sel_i[0])
      begin
         active_en <= dat_i[CTRL_ACTIVE_BIT];
         mode      <= dat_i[CTRL_MODE_LSB +: 3];
      end
   end

   // Pulse counts per channel
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         count_a <= RST_COUNT;
         count_b <= RST_COUNT;
      end
      else if (wr_count)
      begin
         if (sel_i[0])
         begin
            count_a <= dat_i[5:0];
         end
         if (sel_i[1])
         begin
            count_b <= dat_i[COUNT_B_LSB +: 6];
         end
      end
   end

   // High and low times of channel A
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         chan_a_high_time <= RST_TIME;
         chan_a_low_time  <= RST_TIME;
      end
      else if (wr_time)
      begin
         if (sel_i[1:0] == 2'h3)
         begin
            chan_a_high_time <= dat_i[10:0];
         end
         if (sel_i[3:2] == 2'h3)
         begin
            chan_a_low_time <= dat_i[TIME_LOW_LSB +: 11];
         end
      end
   end

   // Guard interval
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         guard_interval <= RST_GUARD;
      end
      else if (wr_guard && sel_i[0])
      begin
         guard_interval <= dat_i[7:0];
      end
   end

   // Trigger: a written 1 starts a burst, ignored while unpowered or busy.
   // A retrigger mid-burst would restart one channel only and break the
   // push-pull phase relation, so it is dropped rather than queued.
   assign trig_a = wr_ctrl && sel_i[0] && dat_i[CTRL_TRIG_A_BIT]
                   && active_en && !busy_a && !busy_b;

   // Read-back; unmapped offsets read zero
   always_comb
   begin
      rdata = 32'h0000_0000;
      unique case (adr_i)
         OFS_CTRL:   rdata = {27'h0, mode, 1'b0, active_en};
         OFS_COUNT:  rdata = {18'h0, count_b, 2'h0, count_a};
         OFS_TIME:   rdata = {5'h0, chan_a_low_time, 5'h0, chan_a_high_time};
         OFS_GUARD:  rdata = {24'h0, guard_interval};
         OFS_STATUS: rdata = {28'h0, low_switch_two_o, low_switch_one_o, busy_b, busy_a};
         default:    rdata = 32'h0000_0000;
      endcase
   end

   // ***************************************************************
   // 16 MHz time base
   // ***************************************************************
   // Fractional divider: 16 ticks per 250 clocks, 15 or 16 clocks apart.
   // The sum is one bit wider than the accumulator so that it cannot
   // wrap before it is compared.
   assign tick_sum = {1'b0, tick_acc} + {1'b0, TICK_ADD};

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         tick_acc <= 8'h00;
         tick     <= 1'b0;
      end
      else if (tick_sum >= {1'b0, TICK_MOD})
      begin
         tick_acc <= 8'(tick_sum - {1'b0, TICK_MOD});
         tick     <= 1'b1;
      end
      else
      begin
         tick_acc <= tick_sum[7:0];
         tick     <= 1'b0;
      end
   end

   // ***************************************************************
   // Channel timing
   // ***************************************************************
   // B sits inside A's low phase, a guard interval from each edge:
   // A high for high ticks, a guard, B high for low minus two guards,
   // then a guard before A rises again. B's low phase is A's high phase
   // plus two guards, so both trains keep one period. A low time shorter
   // than two guards leaves B's slot empty.
   assign guard2 = {3'h0, guard_interval, 1'b0};
   assign b_high = ({1'b0, chan_a_low_time} > guard2) ?
                   ({1'b0, chan_a_low_time} - guard2) : 12'h000;

   always_comb
   begin
      cfg_a.count = count_a;
      cfg_a.lead  = 12'h000;
      cfg_a.high  = {1'b0, chan_a_high_time};
      cfg_a.low   = {1'b0, chan_a_low_time};
      cfg_b.count = count_b;
      cfg_b.lead  = {1'b0, chan_a_high_time} + {4'h0, guard_interval} + 12'h001;
      cfg_b.high  = b_high;
      cfg_b.low   = {1'b0, chan_a_high_time} + guard2;
   end

   // Configuration decode; B joins the burst only in push-pull
   assign push_pull = (mode == UBG_MODE_PUSH_PULL);
   assign start_b   = trig_a && push_pull;

   // Channel A sets the reference train
   ubg_chan u_chan_a
   (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .tick_i  (tick),
      .start_i (trig_a),
      .cfg_i   (cfg_a),
      .pulse_o (pulse_a),
      .busy_o  (busy_a)
   );

   // Channel B, started together with A
   ubg_chan u_chan_b
   (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .tick_i  (tick),
      .start_i (start_b),
      .cfg_i   (cfg_b),
      .pulse_o (pulse_b),
      .busy_o  (busy_b)
   );

   // ***************************************************************
   // Gate outputs
   // ***************************************************************
   // Output selection by configuration, registered so that the gates
   // never see a decode glitch
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         low_switch_one_o <= 1'b0;
         low_switch_two_o <= 1'b0;
      end
      else
      begin
         unique case (mode)
            UBG_MODE_PUSH_PULL:
            begin
               low_switch_one_o <= pulse_a && !pulse_b;
               low_switch_two_o <= pulse_b && !pulse_a;
            end
            UBG_MODE_PORT_B:
            begin
               low_switch_one_o <= pulse_a;
               low_switch_two_o <= port_pin_for_b_i;
            end
            default: // Unsupported codes keep both off
            begin
               low_switch_one_o <= 1'b0;
               low_switch_two_o <= 1'b0;
            end
         endcase
      end
   end

endmodule : ubg_top

// *** ubg_top_assertions.sv ***
/* Checker of ubg_top: bus answer, gate safety and drive modes.
   Assumes it is bound to ubg_top and sees only its ports. */
`timescale 1ns/1ps
module ubg_top_assertions
(
   input wire logic        clk_i,
   input wire logic        rst_i,
   input wire logic        cyc_i,
   input wire logic        stb_i,
   input wire logic        we_i,
   input wire logic [7:0]  adr_i,
   input wire logic [3:0]  sel_i,
   input wire logic [31:0] dat_i,
   input wire logic        ack_o,
   input wire logic [31:0] dat_o,
   input wire logic        port_pin_for_b_i,
   input wire logic        low_switch_one_o,
   input wire logic        low_switch_two_o
);
   import ubg_pkg::*;
   logic [2:0] mode_q;
   logic       act_q;
   // Shadow of mode and active fields
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         mode_q <= 3'h0;
         act_q  <= 1'b0;
      end
      else if (cyc_i && stb_i && we_i && ack_o && adr_i == OFS_CTRL && sel_i[0])
      begin
         mode_q <= dat_i[4:2];
         act_q  <= dat_i[0];
      end
   end
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   a_ack_next: assert property (cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o)
      else $error("ack not a single pulse one cycle after request");
   a_reset_quiet: assert property ($past(rst_i) |-> !ack_o && !low_switch_one_o && !low_switch_two_o)
      else $error("outputs active after reset");
   a_no_overlap: assert property (mode_q == 3'h0 |-> !(low_switch_one_o && low_switch_two_o))
      else $error("both gates on in push-pull");
   a_b_after_gap: assert property ($rose(low_switch_two_o) && mode_q == 3'h0
      |-> !$past(low_switch_one_o) && !$past(low_switch_one_o, 8))
      else $error("gate two rose without guard gap");
   a_port_follow: assert property (mode_q == 3'h1 && $past(mode_q) == 3'h1
      |-> low_switch_two_o == $past(port_pin_for_b_i))
      else $error("gate two not following port pin");
   a_bad_mode_off: assert property (mode_q[2:1] != 2'b00 && $past(mode_q[2:1]) != 2'b00
      |-> !low_switch_one_o && !low_switch_two_o)
      else $error("gate on in unsupported mode");
   a_burst_armed: assert property ($rose(low_switch_one_o) && mode_q[2:1] == 2'b00 |-> act_q)
      else $error("burst without active enable");
   a_pp_two_on: assert property ($rose(low_switch_two_o) |-> mode_q == 3'h0 || mode_q == 3'h1)
      else $error("gate two rose in wrong mode");
   c_push_pull: cover property ($rose(low_switch_two_o) && mode_q == 3'h0);
   c_port: cover property (mode_q == 3'h1 && low_switch_two_o);
   c_bad: cover property (mode_q == 3'h2 && act_q);
endmodule : ubg_top_assertions

bind ubg_top ubg_top_assertions ubg_top_assertions_i (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i,
   .sel_i, .dat_i, .ack_o, .dat_o, .port_pin_for_b_i, .low_switch_one_o, .low_switch_two_o);

// *** ubg_wb_slave.sv ***
/*
 * Classic Wishbone handshake for the burst generator registers: one
 * registered ack per request, read data captured in the request cycle.
 * Assumes the master holds the request until it sees ack.
 */
`timescale 1ns/1ps
module ubg_wb_slave
(
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        cyc_i,
   input  wire logic        stb_i,
   input  wire logic        we_i,
   input  wire logic [31:0] rdata_i,
   output logic             ack_o,
   output logic [31:0]      dat_o,
   output logic             wr_o
);
   import ubg_pkg::*;

   // ***************************************************************
   // Handshake
   // ***************************************************************
   // Ack one cycle after the request, dropped the cycle after
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ack_o <= 1'b0;
         dat_o <= 32'h0000_0000;
      end
      else
      begin
         ack_o <= cyc_i && stb_i && !ack_o;
         if (cyc_i && stb_i && !ack_o)
         begin
            dat_o <= we_i ? 32'h0000_0000 : rdata_i;
         end
      end
   end

   // Write takes effect at the acking edge
   assign wr_o = cyc_i && stb_i && we_i && ack_o;

endmodule : ubg_wb_slave

// *** ubg_xducer_model.sv ***
/* Far side of the two low-side switches: counts gate pulses,
   measures phase lengths in clocks and flags overlap.
   Assumes gates are synchronous to clk_i. */
`timescale 1ns/1ps
module ubg_xducer_model
(
   input  wire logic  clk_i,
   input  wire logic  clr_i,
   input  wire logic  gate_a_i,
   input  wire logic  gate_b_i,
   output logic [7:0] cnt_a_o,
   output logic [7:0] cnt_b_o,
   output logic [15:0] hi_a_o,
   output logic [15:0] lo_a_o,
   output logic [15:0] hi_b_o,
   output logic        overlap_o
);
   logic        a_q;
   logic        b_q;
   logic [15:0] run_a;
   logic [15:0] run_b;
   // Pulse counts, phase lengths, overlap
   always_ff @(posedge clk_i)
   begin
      a_q   <= gate_a_i;
      b_q   <= gate_b_i;
      run_a <= (gate_a_i != a_q) ? 16'h1 : run_a + 16'h1;
      run_b <= (gate_b_i != b_q) ? 16'h1 : run_b + 16'h1;
      if (clr_i)
      begin
         cnt_a_o   <= 8'h00;
         cnt_b_o   <= 8'h00;
         overlap_o <= 1'b0;
      end
      else
      begin
         if (gate_a_i && !a_q)
            cnt_a_o <= cnt_a_o + 8'h1;
         if (gate_b_i && !b_q)
            cnt_b_o <= cnt_b_o + 8'h1;
         if (gate_a_i && gate_b_i)
            overlap_o <= 1'b1;
      end
      if (!gate_a_i && a_q)
         hi_a_o <= run_a;
      if (gate_a_i && !a_q)
         lo_a_o <= run_a;
      if (!gate_b_i && b_q)
         hi_b_o <= run_b;
   end
endmodule : ubg_xducer_model
